// *** hw/rgbbl_defines.svh ***
/*
  Offsets, field positions, reset values and timing counts of the RGB
  blanking and cut-off status block. Assumes a 25 MHz system clock.
*/
`ifndef RGBBL_DEFINES_SVH
`define RGBBL_DEFINES_SVH

// Register byte offsets
`define RGBBL_CTRL_OFS 32'h00000000
`define RGBBL_LEVEL_OFS 32'h00000004
`define RGBBL_STAT_OFS 32'h00000008
`define RGBBL_PHASE_OFS 32'h0000000c

// Control register fields
`define RGBBL_CB_ADJ_LSB 0
`define RGBBL_WB_PHASE_LSB 4
`define RGBBL_WB_EN_BIT 8
`define RGBBL_FORCE_BIT 9
`define RGBBL_REL_LSB 10
`define RGBBL_DBL_BIT 12
`define RGBBL_BLEND_BIT 13
`define RGBBL_BKS_BIT 14
`define RGBBL_CTRL_MASK 32'h00007fff
`define RGBBL_CTRL_RST 32'h00000000

// Level register fields and reset (nominal contrast, saturation, drive)
`define RGBBL_CONTRAST_LSB 0
`define RGBBL_SAT_LSB 8
`define RGBBL_DRIVE_LSB 16
`define RGBBL_BRIGHT_LSB 24
`define RGBBL_LEVEL_MASK 32'h3f0f3f3f
`define RGBBL_LEVEL_RST 32'h20081620
`define RGBBL_CONTRAST_NOM 6'h20
`define RGBBL_SAT_NOM 6'h16
`define RGBBL_DRIVE_NOM 6'h08

// Line timing in line-locked clock pulses; clock periods in ps, overlaps in ns
`define RGBBL_CB_LEAD_LLC 40
`define RGBBL_CB_STEP_LLC 2
`define RGBBL_WB_BASE_LLC 8
`define RGBBL_WB_STEP_LLC 4
`define RGBBL_WB_WIDTH_LLC 60
`define RGBBL_LLC_PS_1F 145000
`define RGBBL_LLC_PS_2F 72500
`define RGBBL_WB_OVL_1F_NS 1000
`define RGBBL_WB_OVL_2F_NS 500
`define RGBBL_WB_OVL_1F_LLC ((`RGBBL_WB_OVL_1F_NS * 1000 + `RGBBL_LLC_PS_1F / 2) / `RGBBL_LLC_PS_1F)
`define RGBBL_WB_OVL_2F_LLC ((`RGBBL_WB_OVL_2F_NS * 1000 + `RGBBL_LLC_PS_2F / 2) / `RGBBL_LLC_PS_2F)

// Start-up hold of the out-of-range flag
`define RGBBL_MCLK_HZ 25000000
`define RGBBL_HOLD_MS 500
`define RGBBL_HOLD_CYCLES (`RGBBL_HOLD_MS * (`RGBBL_MCLK_HZ / 1000))

// Cut-off level thresholds in millivolts
`define RGBBL_LOOP_LO_MV 12'd1500
`define RGBBL_LOOP_HI_MV 12'd3500
`define RGBBL_WIN_LO_MV 12'd2400
`define RGBBL_WIN_HI_MV 12'd2600
`define RGBBL_DIR_MV 12'd2600

// Bus responses
`define RGBBL_RESP_OKAY 2'h0
`define RGBBL_RESP_SLVERR 2'h2

`endif

// *** hw/rgbbl_pkg.sv ***
/*
  Types of the RGB blanking and cut-off status block: AXI4-Lite carriers
  and the cut-off measurement bundle. Assumes 32-bit AXI4-Lite data.
*/
package rgbbl_pkg;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } rgbbl_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rgbbl_axi_rsp_t;

  // One cut-off measurement, levels in millivolts
  typedef struct packed {
    logic valid;
    logic [11:0] lvl_r;
    logic [11:0] lvl_g;
    logic [11:0] lvl_b;
  } rgbbl_cutoff_t;

endpackage

// *** hw/rgbbl_axil.sv ***
/*
  AXI4-Lite slave shell: handshakes, write and read strobes, responses.
  Assumes the register file answers rd_data, rd_ok and wr_ok combinationally
  from the request addresses.
*/
`timescale 1ns/1ps
`include "rgbbl_defines.svh"

module rgbbl_axil
(
  input wire logic clk,
  input wire logic rst_n,
  input wire rgbbl_pkg::rgbbl_axi_req_t req,
  output rgbbl_pkg::rgbbl_axi_rsp_t rsp,
  output logic wr_en,
  input wire logic wr_ok,
  output logic rd_en,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  import rgbbl_pkg::*;

  // Strobes mark the edge at which an address is taken
  assign wr_en = rsp.awready & req.awvalid & rsp.wready & req.wvalid;
  assign rd_en = rsp.arready & req.arvalid;

  // Write channel: address and data are taken together, one write at a time
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp.awready <= 1'b0;
      rsp.wready <= 1'b0;
      rsp.bvalid <= 1'b0;
      rsp.bresp <= `RGBBL_RESP_OKAY;
    end
    else
    begin
      if (rsp.awready)
      begin
        rsp.awready <= 1'b0;
        rsp.wready <= 1'b0;
      end
      else if (req.awvalid && req.wvalid && !rsp.bvalid)
      begin
        rsp.awready <= 1'b1;
        rsp.wready <= 1'b1;
      end
      if (wr_en)
      begin
        rsp.bvalid <= 1'b1;
        rsp.bresp <= wr_ok ? `RGBBL_RESP_OKAY : `RGBBL_RESP_SLVERR;
      end
      else if (req.bready)
        rsp.bvalid <= 1'b0;
    end
  end

  // Read channel: data captured at the address edge, held until taken
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp.arready <= 1'b0;
      rsp.rvalid <= 1'b0;
      rsp.rdata <= 32'h00000000;
      rsp.rresp <= `RGBBL_RESP_OKAY;
    end
    else
    begin
      if (rsp.arready)
        rsp.arready <= 1'b0;
      else if (req.arvalid && !rsp.rvalid)
        rsp.arready <= 1'b1;
      if (rd_en)
      begin
        rsp.rvalid <= 1'b1;
        rsp.rdata <= rd_ok ? rd_data : 32'h00000000;
        rsp.rresp <= rd_ok ? `RGBBL_RESP_OKAY : `RGBBL_RESP_SLVERR;
      end
      else if (req.rready)
        rsp.rvalid <= 1'b0;
    end
  end

endmodule

// *** hw/rgbbl_top.sv ***
/*
  RGB output blanking, wide blanking, cathode loop start-up sequencing and
  cut-off status, with control over AXI4-Lite.
  Assumes the line-locked clock, flyback, sync and cut-off measurement
  inputs are asynchronous pins; cut-off levels are stable while valid is high.
*/
// Functional notes
// - Counter blanking starts 40 LINE_LOCKED_CLOCK before flyback centre
// - Blanking ends on flyback trailing edge
// - Four-bit field shifts counter blanking start
// - Enable bit adds sync-locked wide blanking pulse
// - Four-bit field sets wide blanking phase
// - Wide pulse overlaps about 1 or 0.5 us
// - Release blanks outputs and enables calibration loop
// - Out-of-range flag set outside 1.5-3.5 V
// - Start-up blanking ends when flag falls
// - Flag cannot clear for 0.5 s after release
// - Force bit holds outputs blanked
// - Window-ok when lowest level within 2.5+-0.1 V
// - Direction bit: lowest level above 2.6 V
// - Overlay mode: fast switch or blending
// - Control bit enables black level stretch
// - Overlay input gets only brightness control
// - Contrast 32 and saturation 22 are nominal
// - Drive level 1000 binary is nominal
// - Phase detector referenced to sync leading edge
`timescale 1ns/1ps
`include "rgbbl_defines.svh"

module rgbbl_top
#(
  parameter int LW = 11,
  parameter int unsigned HOLD_CYCLES = `RGBBL_HOLD_CYCLES
)
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic LINE_LOCKED_CLOCK,
  input wire logic FLYBACK,
  input wire logic HSYNC,
  input wire rgbbl_pkg::rgbbl_cutoff_t CUTOFF,
  input wire rgbbl_pkg::rgbbl_axi_req_t AXI_REQ,
  output rgbbl_pkg::rgbbl_axi_rsp_t AXI_RSP,
  output logic RGB_BLANK,
  output logic CCC_ENABLE,
  output logic OVERLAY_BLEND,
  output logic BLACK_STRETCH,
  output logic signed [6:0] CONTRAST_DELTA,
  output logic signed [6:0] SATURATION_DELTA,
  output logic signed [6:0] DRIVE_DELTA,
  output logic [5:0] MAIN_BRIGHTNESS,
  output logic [5:0] OVL_BRIGHTNESS,
  output logic [LW-1:0] HPHASE
);
  import rgbbl_pkg::*;

  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [2:0] pin_d;
  rgbbl_cutoff_t cut_s1;
  rgbbl_cutoff_t cut_s2;
  logic cut_vd;
  logic llc_rise;
  logic fb_rise;
  logic fb_fall;
  logic hs_rise;
  logic meas_new;
  logic [31:0] ctrl;
  logic [31:0] level;
  logic wr_en;
  logic wr_ok;
  logic rd_en;
  logic [31:0] rd_data;
  logic rd_ok;
  logic [LW-1:0] cnt;
  logic [LW-1:0] fb_lead;
  logic [LW-1:0] cb_start_pos;
  logic cb_ok;
  logic cb_active;
  logic wb_active;
  logic [LW-1:0] wb_start;
  logic [LW-1:0] wb_end;
  logic [LW-1:0] ovl;
  logic [LW-1:0] next_centre;
  logic [LW:0] next_cb_start;
  logic released;
  logic rel_d;
  logic rel_rise;
  logic [23:0] hold_cnt;
  logic loop_flag;
  logic startup_blank;
  logic window_ok;
  logic above_thr;
  logic [11:0] lowest;
  logic out_of_range;
  logic force_blank;
  logic wb_en;

  // Smaller of two levels
  function automatic logic [11:0] min_mv(input logic [11:0] a, input logic [11:0] b);
    min_mv = (a < b) ? a : b;
  endfunction

  // Level lies inside [lo, hi]
  function automatic logic in_range(input logic [11:0] v, input logic [11:0] lo, input logic [11:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // Byte-lane merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    merge = old;
    for (int i = 0; i < 4; i++)
      if (s[i])
        merge[i*8 +: 8] = d[i*8 +: 8];
  endfunction

  // Signed distance of a setting from its nominal code
  function automatic logic signed [6:0] nom_delta(input logic [5:0] v, input logic [5:0] nom);
    nom_delta = $signed({1'b0, v}) - $signed({1'b0, nom});
  endfunction

  // Two-flop synchronisers on every pin; the third stage feeds edge detection
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_d <= 3'h0;
      cut_s1 <= '0;
      cut_s2 <= '0;
      cut_vd <= 1'b0;
    end
    else
    begin
      pin_s1 <= {LINE_LOCKED_CLOCK, FLYBACK, HSYNC};
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
      cut_s1 <= CUTOFF;
      cut_s2 <= cut_s1;
      cut_vd <= cut_s2.valid;
    end
  end

  assign llc_rise = pin_s2[2] & ~pin_d[2];
  assign fb_rise = pin_s2[1] & ~pin_d[1];
  assign fb_fall = ~pin_s2[1] & pin_d[1];
  assign hs_rise = pin_s2[0] & ~pin_d[0];
  assign meas_new = cut_s2.valid & ~cut_vd;

  // Control fields
  assign force_blank = ctrl[`RGBBL_FORCE_BIT];
  assign wb_en = ctrl[`RGBBL_WB_EN_BIT];
  assign released = &ctrl[`RGBBL_REL_LSB +: 2];
  assign rel_rise = released & ~rel_d;

  // Register writes; only the two control words are writable
  assign wr_ok = (AXI_REQ.awaddr == `RGBBL_CTRL_OFS) || (AXI_REQ.awaddr == `RGBBL_LEVEL_OFS);
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ctrl <= `RGBBL_CTRL_RST;
      level <= `RGBBL_LEVEL_RST;
    end
    else if (wr_en)
    begin
      if (AXI_REQ.awaddr == `RGBBL_CTRL_OFS)
        ctrl <= merge(ctrl, AXI_REQ.wdata, AXI_REQ.wstrb) & `RGBBL_CTRL_MASK;
      else if (AXI_REQ.awaddr == `RGBBL_LEVEL_OFS)
        level <= merge(level, AXI_REQ.wdata, AXI_REQ.wstrb) & `RGBBL_LEVEL_MASK;
    end
  end

  // Read decode; unmapped addresses answer with an error
  always_comb
  begin
    rd_data = 32'h00000000;
    rd_ok = 1'b1;
    unique case (AXI_REQ.araddr)
      `RGBBL_CTRL_OFS: rd_data = ctrl;
      `RGBBL_LEVEL_OFS: rd_data = level;
      `RGBBL_STAT_OFS: rd_data = {26'h0, RGB_BLANK, startup_blank, released, above_thr, window_ok, loop_flag};
      `RGBBL_PHASE_OFS: rd_data = {5'h0, cb_start_pos, 5'h0, HPHASE};
      default: rd_ok = 1'b0;
    endcase
  end

  rgbbl_axil u_axil
  (
    .clk(MCLK),
    .rst_n(RST_N),
    .req(AXI_REQ),
    .rsp(AXI_RSP),
    .wr_en(wr_en),
    .wr_ok(wr_ok),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // Line counter of LINE_LOCKED_CLOCK pulses, restarted at each sync leading edge
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      cnt <= '0;
    else if (hs_rise)
      cnt <= '0;
    else if (llc_rise)
      cnt <= cnt + 1'b1;
  end

  // Flyback centre measured this line predicts next line; negative start clips to zero
  assign next_centre = LW'((({1'b0, fb_lead} + {1'b0, cnt}) >> 1));
  assign next_cb_start = {1'b0, next_centre} - (LW+1)'(`RGBBL_CB_LEAD_LLC)
    - (LW+1)'(ctrl[`RGBBL_CB_ADJ_LSB +: 4] * `RGBBL_CB_STEP_LLC);

  // Flyback edges: phase of the flyback centre from the sync edge, blank start
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      fb_lead <= '0;
      cb_start_pos <= '0;
      cb_ok <= 1'b0;
      HPHASE <= '0;
    end
    else
    begin
      if (fb_rise)
        fb_lead <= cnt;
      if (fb_fall)
      begin
        HPHASE <= next_centre;
        cb_start_pos <= next_cb_start[LW] ? '0 : next_cb_start[LW-1:0];
        cb_ok <= 1'b1;
      end
    end
  end

  // Counter blanking: started by count, ended only by the flyback
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      cb_active <= 1'b0;
    else if (fb_fall)
      cb_active <= 1'b0;
    else if (llc_rise && cb_ok && cnt == cb_start_pos)
      cb_active <= 1'b1;
  end

  // Wide pulse tied to the sync edge only, so a shrunk scan never shows picture edges
  assign ovl = ctrl[`RGBBL_DBL_BIT] ? LW'(`RGBBL_WB_OVL_2F_LLC) : LW'(`RGBBL_WB_OVL_1F_LLC);
  assign wb_start = LW'(`RGBBL_WB_BASE_LLC + ctrl[`RGBBL_WB_PHASE_LSB +: 4] * `RGBBL_WB_STEP_LLC);
  assign wb_end = wb_start + LW'(`RGBBL_WB_WIDTH_LLC) + (ovl << 1);
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      wb_active <= 1'b0;
    else if (!wb_en)
      wb_active <= 1'b0;
    else if (llc_rise && cnt == wb_start)
      wb_active <= 1'b1;
    else if (llc_rise && cnt == wb_end)
      wb_active <= 1'b0;
  end

  // Cut-off measurement evaluation
  assign lowest = min_mv(min_mv(cut_s2.lvl_r, cut_s2.lvl_g), cut_s2.lvl_b);
  assign out_of_range = !in_range(cut_s2.lvl_r, `RGBBL_LOOP_LO_MV, `RGBBL_LOOP_HI_MV)
    || !in_range(cut_s2.lvl_g, `RGBBL_LOOP_LO_MV, `RGBBL_LOOP_HI_MV)
    || !in_range(cut_s2.lvl_b, `RGBBL_LOOP_LO_MV, `RGBBL_LOOP_HI_MV);
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      window_ok <= 1'b0;
      above_thr <= 1'b0;
    end
    else if (meas_new)
    begin
      window_ok <= in_range(lowest, `RGBBL_WIN_LO_MV, `RGBBL_WIN_HI_MV);
      above_thr <= lowest > `RGBBL_DIR_MV;
    end
  end

  // Start-up hold timer after the horizontal output is released
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rel_d <= 1'b0;
      hold_cnt <= '0;
    end
    else
    begin
      rel_d <= released;
      if (rel_rise)
        hold_cnt <= 24'(HOLD_CYCLES);
      else if (hold_cnt != '0)
        hold_cnt <= hold_cnt - 1'b1;
    end
  end

  // Out-of-range flag: forced on at release so a warm tube still waits out the hold
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      loop_flag <= 1'b0;
      startup_blank <= 1'b0;
    end
    else if (rel_rise)
    begin
      loop_flag <= 1'b1;
      startup_blank <= 1'b1;
    end
    else if (meas_new && out_of_range)
      loop_flag <= 1'b1;
    else if (meas_new && hold_cnt == '0 && loop_flag)
    begin
      loop_flag <= 1'b0;
      startup_blank <= 1'b0;
    end
  end

  // Output stage; force blank overrides the loop state
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      RGB_BLANK <= 1'b1;
      CCC_ENABLE <= 1'b0;
    end
    else
    begin
      RGB_BLANK <= force_blank | startup_blank | cb_active | wb_active;
      CCC_ENABLE <= released;
    end
  end

  // Picture controls; overlay input sees brightness only
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      OVERLAY_BLEND <= 1'b0;
      BLACK_STRETCH <= 1'b0;
      CONTRAST_DELTA <= '0;
      SATURATION_DELTA <= '0;
      DRIVE_DELTA <= '0;
      MAIN_BRIGHTNESS <= '0;
      OVL_BRIGHTNESS <= '0;
    end
    else
    begin
      OVERLAY_BLEND <= ctrl[`RGBBL_BLEND_BIT];
      BLACK_STRETCH <= ctrl[`RGBBL_BKS_BIT];
      CONTRAST_DELTA <= nom_delta(level[`RGBBL_CONTRAST_LSB +: 6], `RGBBL_CONTRAST_NOM);
      SATURATION_DELTA <= nom_delta(level[`RGBBL_SAT_LSB +: 6], `RGBBL_SAT_NOM);
      DRIVE_DELTA <= nom_delta({2'h0, level[`RGBBL_DRIVE_LSB +: 4]}, `RGBBL_DRIVE_NOM);
      MAIN_BRIGHTNESS <= level[`RGBBL_BRIGHT_LSB +: 6];
      OVL_BRIGHTNESS <= level[`RGBBL_BRIGHT_LSB +: 6];
    end
  end

  // Checks
  property p_release_blank;
    @(posedge MCLK) disable iff (!RST_N) rel_rise |=> loop_flag && startup_blank ##1 RGB_BLANK && CCC_ENABLE;
  endproperty
  a_release_blank: assert property (p_release_blank) else $error("release did not blank");

  property p_hold_flag;
    @(posedge MCLK) disable iff (!RST_N) (loop_flag && hold_cnt != '0 && !rel_rise) |=> loop_flag;
  endproperty
  a_hold_flag: assert property (p_hold_flag) else $error("flag cleared during hold");

  property p_unblank;
    @(posedge MCLK) disable iff (!RST_N) $fell(loop_flag) |-> !startup_blank
      ##1 (RGB_BLANK == ($past(force_blank) || $past(cb_active) || $past(wb_active)));
  endproperty
  a_unblank: assert property (p_unblank) else $error("start-up blank kept");

  property p_force;
    @(posedge MCLK) disable iff (!RST_N) force_blank [*2] |-> RGB_BLANK;
  endproperty
  a_force: assert property (p_force) else $error("force blank ignored");

  property p_trail;
    @(posedge MCLK) disable iff (!RST_N) fb_fall |=> !cb_active;
  endproperty
  a_trail: assert property (p_trail) else $error("blank not ended by flyback");

  property p_cb_start;
    @(posedge MCLK) disable iff (!RST_N) (llc_rise && cb_ok && cnt == cb_start_pos && !fb_fall) |=> cb_active ##1 RGB_BLANK;
  endproperty
  a_cb_start: assert property (p_cb_start) else $error("counter blank late");

  property p_oor;
    @(posedge MCLK) disable iff (!RST_N) (meas_new && out_of_range) |=> loop_flag;
  endproperty
  a_oor: assert property (p_oor) else $error("out of range not flagged");

  property p_wide_off;
    @(posedge MCLK) disable iff (!RST_N) !wb_en |=> !wb_active;
  endproperty
  a_wide_off: assert property (p_wide_off) else $error("wide blank while disabled");

  property p_window;
    @(posedge MCLK) disable iff (!RST_N) meas_new && lowest < `RGBBL_WIN_LO_MV |=> !window_ok && !above_thr;
  endproperty
  a_window: assert property (p_window) else $error("window bits wrong");

  property p_line_start;
    @(posedge MCLK) disable iff (!RST_N) hs_rise |=> cnt == '0;
  endproperty
  a_line_start: assert property (p_line_start) else $error("line count not restarted");

  c_unblank: cover property (@(posedge MCLK) disable iff (!RST_N) $fell(startup_blank));
  c_wide: cover property (@(posedge MCLK) disable iff (!RST_N) $rose(wb_active));
  c_cb: cover property (@(posedge MCLK) disable iff (!RST_N) $rose(cb_active) ##[1:600] $fell(cb_active));

endmodule

// *** tb/rgbbl_line_model.sv ***
/*
  Far-side line timing: free-running line-locked clock, sync and flyback.
  Assumes 128 clock pulses per line and a 320 ns clock period.
*/
`timescale 1ns/1ps
module rgbbl_line_model
(
  output logic line_locked_clock,
  output logic hsync,
  output logic flyback,
  output logic [6:0] cnt
);
  // Pins move on the falling clock edge so a count never races its own edge
  initial
  begin
    line_locked_clock = 1'b0;
    hsync = 1'b0;
    flyback = 1'b0;
    cnt = 7'h00;
    forever
    begin
      #160 line_locked_clock = 1'b1;
      cnt = cnt + 7'h01;
      #160 line_locked_clock = 1'b0;
      hsync = (cnt == 7'h00); // One pulse wide sync at count 0
      flyback = (cnt >= 7'h3c) && (cnt < 7'h50); // Flyback from 60 to 80
    end
  end
endmodule

// *** tb/tb_top.sv ***
/*
  Self-checking bench of the RGB blanking block: AXI4-Lite host tasks,
  cut-off measurements and line timing from the far-side model.
  Assumes a shortened start-up hold and a flyback centre at count 70.
*/
`timescale 1ns/1ps
`include "rgbbl_defines.svh"
module tb_top;
  import rgbbl_pkg::*;
  localparam int unsigned HOLD = 50;
  localparam int CTR = 70;
  logic MCLK;
  logic RST_N;
  rgbbl_cutoff_t cut;
  rgbbl_axi_req_t areq;
  rgbbl_axi_rsp_t arsp;
  logic line_locked_clock, hs, fb, rgb_blank, ccc_en, ovl_blend, black_str;
  logic [6:0] cnt;
  logic signed [6:0] con_d, sat_d, drv_d;
  logic [5:0] main_br, ovl_br;
  logic [10:0] hphase;
  logic [31:0] rd;
  logic [1:0] rs;
  int errors;
  int checked;

  rgbbl_line_model u_rgbbl_line_model (.line_locked_clock(line_locked_clock), .hsync(hs), .flyback(fb), .cnt(cnt));
  rgbbl_top #(.LW(11), .HOLD_CYCLES(HOLD)) u_rgbbl_top (.MCLK(MCLK), .RST_N(RST_N),
    .LINE_LOCKED_CLOCK(line_locked_clock), .FLYBACK(fb), .HSYNC(hs), .CUTOFF(cut), .AXI_REQ(areq), .AXI_RSP(arsp),
    .RGB_BLANK(rgb_blank), .CCC_ENABLE(ccc_en), .OVERLAY_BLEND(ovl_blend), .BLACK_STRETCH(black_str),
    .CONTRAST_DELTA(con_d), .SATURATION_DELTA(sat_d), .DRIVE_DELTA(drv_d),
    .MAIN_BRIGHTNESS(main_br), .OVL_BRIGHTNESS(ovl_br), .HPHASE(hphase));

  // 25 MHz system clock
  initial
  begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Write both channels at once and keep bready up until the answer
  task axw(input logic [31:0] a, input logic [31:0] d);
    @(posedge MCLK);
    areq.awaddr <= a;
    areq.wdata <= d;
    areq.wstrb <= 4'hf;
    areq.awvalid <= 1'b1;
    areq.wvalid <= 1'b1;
    areq.bready <= 1'b1;
    do
    begin
      @(posedge MCLK);
      if (arsp.awready === 1'b1) areq.awvalid <= 1'b0;
      if (arsp.wready === 1'b1) areq.wvalid <= 1'b0;
    end
    while (arsp.bvalid !== 1'b1);
    rs = arsp.bresp;
    areq.bready <= 1'b0;
  endtask

  task axr(input logic [31:0] a);
    @(posedge MCLK);
    areq.araddr <= a;
    areq.arvalid <= 1'b1;
    areq.rready <= 1'b1;
    do
    begin
      @(posedge MCLK);
      if (arsp.arready === 1'b1) areq.arvalid <= 1'b0;
    end
    while (arsp.rvalid !== 1'b1);
    rd = arsp.rdata;
    rs = arsp.rresp;
    areq.rready <= 1'b0;
  endtask

  // Sample a few clocks into the given line count, well away from transitions
  task at_cnt(input logic [6:0] c);
    while (cnt === c) @(posedge MCLK);
    do @(posedge MCLK); while (cnt !== c);
    repeat (2) @(posedge MCLK);
    #1;
  endtask

  // Levels are held steady around the valid pulse, as the design needs
  task meas(input logic [11:0] r, input logic [11:0] g, input logic [11:0] b);
    @(posedge MCLK);
    cut.lvl_r <= r;
    cut.lvl_g <= g;
    cut.lvl_b <= b;
    repeat (4) @(posedge MCLK);
    cut.valid <= 1'b1;
    repeat (4) @(posedge MCLK);
    cut.valid <= 1'b0;
    repeat (6) @(posedge MCLK);
  endtask

  task st(input logic [11:0] r, input logic [11:0] g, input logic [11:0] b, input logic [2:0] e);
    meas(r, g, b);
    axr(`RGBBL_STAT_OFS);
    chk(rd[2:0], e);
  endtask

  task t_reset;
    axr(`RGBBL_CTRL_OFS);
    chk(rd, `RGBBL_CTRL_RST);
    axr(`RGBBL_LEVEL_OFS);
    chk(rd, `RGBBL_LEVEL_RST);
    chk(con_d, 32'h0);
    chk(sat_d, 32'h0);
    chk(drv_d, 32'h0);
    chk(ovl_br, 32'h20);
    axw(`RGBBL_STAT_OFS, 32'h1);
    chk(rs, `RGBBL_RESP_SLVERR);
    axr(32'h10);
    chk(rs, `RGBBL_RESP_SLVERR);
    chk(rd, 32'h0);
  endtask

  // Start adjust applies from the next line, so two lines pass first
  task t_line;
    at_cnt(7'd100);
    at_cnt(7'd100);
    chk(hphase, CTR);
    axr(`RGBBL_PHASE_OFS);
    chk(rd[26:16], CTR - `RGBBL_CB_LEAD_LLC);
    at_cnt(7'd25);
    chk(rgb_blank, 1'b0);
    at_cnt(7'd50);
    chk(rgb_blank, 1'b1);
    at_cnt(7'd90);
    chk(rgb_blank, 1'b0);
    axw(`RGBBL_CTRL_OFS, 32'h5);
    at_cnt(7'd100);
    at_cnt(7'd100);
    axr(`RGBBL_PHASE_OFS);
    chk(rd[26:16], CTR - `RGBBL_CB_LEAD_LLC - 5 * `RGBBL_CB_STEP_LLC);
    at_cnt(7'd25);
    chk(rgb_blank, 1'b1);
  endtask

  // Wide pulse from 8+4*phase to start+60+2*7; counter blank runs 30 to 80
  task t_wide;
    axw(`RGBBL_CTRL_OFS, 32'h130);
    at_cnt(7'd100);
    at_cnt(7'd10);
    chk(rgb_blank, 1'b0);
    at_cnt(7'd25);
    chk(rgb_blank, 1'b1);
    at_cnt(7'd90);
    chk(rgb_blank, 1'b1);
    at_cnt(7'd110);
    chk(rgb_blank, 1'b0);
    axw(`RGBBL_CTRL_OFS, 32'h1100);
    at_cnt(7'd10);
    chk(rgb_blank, 1'b1);
    at_cnt(7'd81);
    chk(rgb_blank, 1'b1);
    axw(`RGBBL_CTRL_OFS, 32'h0);
  endtask

  // First in-range measurement lands inside the hold and must not clear
  task t_startup;
    axw(`RGBBL_CTRL_OFS, 32'hc00);
    meas(12'd2500, 12'd2500, 12'd2500);
    axr(`RGBBL_STAT_OFS);
    chk(rd[0], 1'b1);
    chk(ccc_en, 1'b1);
    at_cnt(7'd10);
    chk(rgb_blank, 1'b1);
    st(12'd2500, 12'd2550, 12'd2590, 3'b010);
    at_cnt(7'd10);
    chk(rgb_blank, 1'b0);
    st(12'd2600, 12'd2700, 12'd2700, 3'b010);
    st(12'd2700, 12'd2800, 12'd2900, 3'b100);
    st(12'd1400, 12'd2500, 12'd2500, 3'b001);
    st(12'd2500, 12'd3600, 12'd2500, 3'b011);
    st(12'd2401, 12'd2500, 12'd3500, 3'b010);
  endtask

  task t_misc;
    axw(`RGBBL_CTRL_OFS, 32'h6e00);
    at_cnt(7'd10);
    chk(rgb_blank, 1'b1);
    chk(ovl_blend, 1'b1);
    chk(black_str, 1'b1);
    // Host lets the picture settle before lifting the forced blank
    repeat (20) @(posedge MCLK);
    axw(`RGBBL_CTRL_OFS, 32'hc00);
    at_cnt(7'd10);
    chk(rgb_blank, 1'b0);
    chk(ovl_blend, 1'b0);
    chk(black_str, 1'b0);
    axw(`RGBBL_LEVEL_OFS, 32'h10091721);
    repeat (2) @(posedge MCLK);
    chk(con_d, 32'h1);
    chk(sat_d, 32'h1);
    chk(drv_d, 32'h1);
    chk(main_br, 32'h10);
    chk(ovl_br, 32'h10);
  endtask

  // Reset, then the scenarios in turn
  initial
  begin
    RST_N = 1'b0;
    areq = '0;
    cut = '0;
    errors = 0;
    checked = 0;
    repeat (5) @(posedge MCLK);
    #1;
    chk(rgb_blank, 1'b1);
    chk(ccc_en, 1'b0);
    repeat (5) @(posedge MCLK);
    RST_N <= 1'b1;
    t_reset();
    t_line();
    t_wide();
    t_startup();
    t_misc();
    give_verdict();
  end

  // About eight times the expected run length
  initial
  begin
    repeat (80000) @(posedge MCLK);
    errors++;
    give_verdict();
  end
endmodule
